// ---- hdl/lmc_channel.sv ----
`include "lmc_defs.svh"
`default_nettype none
module lmc_channel
   import lmc_pkg::*;
(
   input  wire logic          sys_clk_i,
   input  wire logic          rst_b_i,
   input  wire lmc_mode_t     mode_i,
   input  wire logic          mode_new_i,
   input  wire logic          rearm_i,
   input  wire logic          tx_i,
   input  wire logic          bus_i,
   output lmc_chan_out_t      out_o
);
   typedef enum logic [3:0] {
      LMC_CH_IDLE  = 4'h1,
      LMC_CH_EN    = 4'h2,
      LMC_CH_ARMED = 4'h4,
      LMC_CH_RUN   = 4'h8
   } lmc_ch_state_t;

   lmc_ch_state_t           st_reg;
   lmc_ch_state_t           st_next;
   logic [`LMC_EN_CNT_W-1:0] en_cnt_reg;
   logic [`LMC_WK_CNT_W-1:0] wk_cnt_reg;
   logic                    wake_reg;
   logic                    wk_long_reg;
   logic                    tx_drv_reg;
   logic                    rx_reg;

   ////////////////////////////////////////////////////////////////////////
   // Enabling sequence
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         LMC_CH_IDLE: begin
            if (mode_i == LMC_MODE_NORM) begin
               st_next = LMC_CH_EN;
            end
         end
         LMC_CH_EN: begin
            if (en_cnt_reg == `LMC_EN_CNT_W'(`LMC_EN_CYCLES - 1)) begin
               st_next = tx_i ? LMC_CH_RUN : LMC_CH_ARMED;
            end
         end
         LMC_CH_ARMED: begin
            if (tx_i) begin
               st_next = LMC_CH_RUN;
            end
         end
         LMC_CH_RUN: st_next = st_reg;
         default:    st_next = LMC_CH_IDLE;
      endcase
      if (mode_i != LMC_MODE_NORM || mode_new_i) begin
         st_next = (mode_i == LMC_MODE_NORM) ? LMC_CH_EN : LMC_CH_IDLE;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_reg <= LMC_CH_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         en_cnt_reg <= '0;
      end else if (st_reg == LMC_CH_EN && st_next == LMC_CH_EN && !mode_new_i) begin
         en_cnt_reg <= en_cnt_reg + `LMC_EN_CNT_W'(1);
      end else begin
         en_cnt_reg <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Driver: only the running state may go dominant
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_drv_reg <= 1'h0;
      end else begin
         tx_drv_reg <= (st_next == LMC_CH_RUN) && !tx_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wake detect: long dominant then rising edge; off mode ignores all
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wk_cnt_reg  <= '0;
         wk_long_reg <= 1'h0;
      end else if (mode_i != LMC_MODE_WAKE || bus_i) begin
         wk_cnt_reg  <= '0;
         wk_long_reg <= wk_long_reg && !bus_i && mode_i == LMC_MODE_WAKE;
         if (mode_i != LMC_MODE_WAKE) begin
            wk_long_reg <= 1'h0;
         end
      end else if (wk_cnt_reg == `LMC_WK_CNT_W'(`LMC_WK_CYCLES - 1)) begin
         wk_long_reg <= 1'h1;
      end else begin
         wk_cnt_reg <= wk_cnt_reg + `LMC_WK_CNT_W'(1);
      end
   end

   // Wake latch survives until another mode is written or a rearm
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wake_reg <= 1'h0;
      end else if (mode_i == LMC_MODE_WAKE && wk_long_reg && bus_i) begin
         wake_reg <= 1'h1;
      end else if (mode_i != LMC_MODE_WAKE || rearm_i) begin
         wake_reg <= 1'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive output
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_reg <= 1'h1;
      end else begin
         case (mode_i)
            LMC_MODE_NORM: rx_reg <= bus_i;
            LMC_MODE_RXO:  rx_reg <= bus_i;
            LMC_MODE_WAKE: rx_reg <= !wake_reg;
            default:       rx_reg <= 1'h1;
         endcase
      end
   end

   assign out_o = '{tx_drive: tx_drv_reg, rx_level: rx_reg,
                    wake_seen: wake_reg, en_done: st_reg == LMC_CH_RUN};

   a_drv_blocked: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      mode_i != LMC_MODE_NORM |=> !tx_drv_reg)
      else $error("driver active outside normal mode");
   // Leaving early for off or a rewrite is legal; only the count end may arm
   a_en_delay: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      st_reg == LMC_CH_EN && en_cnt_reg != `LMC_EN_CNT_W'(`LMC_EN_CYCLES - 1)
      |=> st_reg == LMC_CH_EN || st_reg == LMC_CH_IDLE)
      else $error("enabling delay shorter than expected");
   a_off_quiet: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      mode_i == LMC_MODE_OFF ##1 mode_i == LMC_MODE_OFF |-> !wake_reg && rx_reg)
      else $error("off mode shows activity");
   a_armed_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      st_reg == LMC_CH_ARMED && !tx_i && mode_i == LMC_MODE_NORM && !mode_new_i
      |=> !tx_drv_reg)
      else $error("stale low transmitted");
   a_rx_follow: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      mode_i == LMC_MODE_RXO |=> rx_reg == $past(bus_i))
      else $error("receive level not passed");
   a_wake_low: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      wake_reg && mode_i == LMC_MODE_WAKE |=> !rx_reg)
      else $error("receive not low after wake");
endmodule
`default_nettype wire

// ---- hdl/lmc_defs.svh ----
// Functional notes
// - After power-up both transceivers sit in off mode, no transmit, no receive.
// - Off mode may be selected in every chip operating mode.
// - In off mode bus wake activity is ignored and never recorded.
// - Normal mode is enabled by writing the mode field in chip normal mode.
// - Normal transceiver mode exists only in chip normal or stop mode.
// - In normal mode, transmit input low drives dominant, high drives recessive.
// - No transmission onto the bus until the enabling delay has elapsed.
// - A low held through the delay is suppressed; next dominant bit is sent.
// - Where reception is active, receive output is low dominant, high recessive.
// - Receive-only mode keeps the driver off yet passes bus level to receive.
// - Receive-only mode is selected by command, only in chip normal or stop.
// - Each transceiver has its own mode field that alone sets its mode; code also forces normal and receive-only to off in chip sleep or other.
// - Operation at the reduced 10.4 kbit/s data rate is supported.
// - Wake-capable mode code is 01; field keeps 01 after wake until rewritten.
// - After a wake in wake-capable mode, receive output stays low until mode change; code also releases it on a rearm (entering stop or sleep).
`ifndef LMC_DEFS_SVH
`define LMC_DEFS_SVH
`define LMC_CLK_MHZ        10
`define LMC_EN_TIME_US     8
`define LMC_EN_CYCLES      (`LMC_EN_TIME_US * `LMC_CLK_MHZ)
`define LMC_EN_CNT_W       8
`define LMC_WK_TIME_US     30
`define LMC_WK_CYCLES      (`LMC_WK_TIME_US * `LMC_CLK_MHZ)
`define LMC_WK_CNT_W       10
`define LMC_NUM_CH         2
`define LMC_BAUD_SLOW_BPS  10400
`endif

// ---- hdl/lmc_pkg.sv ----
`default_nettype none
package lmc_pkg;
   // Mode field codes
   typedef enum logic [1:0] {
      LMC_MODE_OFF  = 2'h0,
      LMC_MODE_WAKE = 2'h1,
      LMC_MODE_RXO  = 2'h2,
      LMC_MODE_NORM = 2'h3
   } lmc_mode_t;
   typedef enum logic [3:0] {
      LMC_SYS_NORMAL  = 4'h1,
      LMC_SYS_STOP    = 4'h2,
      LMC_SYS_SLEEP   = 4'h4,
      LMC_SYS_OTHER   = 4'h8
   } lmc_sys_t;
   // Pins of one channel towards controller and bus
   typedef struct packed {
      logic tx_drive;   // Dominant drive of the output stage
      logic rx_level;   // Receive output level
      logic wake_seen;  // Wake latched
      logic en_done;    // Running state reached (delay over and transmit input high)
   } lmc_chan_out_t;
endpackage
`default_nettype wire

// ---- hdl/lmc_sync3.sv ----
`default_nettype none
module lmc_sync3
   import lmc_pkg::*;
(
   input  wire logic sys_clk_i,
   input  wire logic rst_b_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   // Change taken once second and third stage agree; reset level is recessive
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_reg <= 1'h1;
         s2_reg <= 1'h1;
         s3_reg <= 1'h1;
         q_o    <= 1'h1;
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            q_o <= s3_reg;
         end
      end
   end
endmodule
`default_nettype wire

// ---- hdl/lmc_top.sv ----
`include "lmc_defs.svh"
`default_nettype none
module lmc_top
   import lmc_pkg::*;
(
   input  wire logic                   sys_clk_i,
   input  wire logic                   rst_b_i,
   input  wire lmc_sys_t               sys_mode_i,
   input  wire lmc_mode_t              bus_channel_one_mode_i,
   input  wire lmc_mode_t              bus_channel_two_mode_i,
   input  wire logic                   frame_done_i,
   input  wire logic [`LMC_NUM_CH-1:0] bus_transmit_input_i,
   input  wire logic [`LMC_NUM_CH-1:0] bus_level_i,
   output logic [`LMC_NUM_CH-1:0]      bus_drive_o,
   output logic [`LMC_NUM_CH-1:0]      bus_drive_oe_o,
   output logic [`LMC_NUM_CH-1:0]      rx_o,
   output logic [`LMC_NUM_CH-1:0]      wake_o,
   output lmc_mode_t [`LMC_NUM_CH-1:0] mode_o
);
   lmc_mode_t     mode_reg [`LMC_NUM_CH];
   lmc_mode_t     wr_mode  [`LMC_NUM_CH];
   lmc_sys_t      sys_prev_reg;
   logic          rearm;
   lmc_chan_out_t ch_out   [`LMC_NUM_CH];

   assign wr_mode[0] = bus_channel_one_mode_i;
   assign wr_mode[1] = bus_channel_two_mode_i;
   // Entering stop or sleep rearms wake capability
   assign rearm = (sys_mode_i != sys_prev_reg) &&
                  (sys_mode_i == LMC_SYS_STOP || sys_mode_i == LMC_SYS_SLEEP);

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sys_prev_reg <= LMC_SYS_NORMAL;
      end else begin
         sys_prev_reg <= sys_mode_i;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `LMC_NUM_CH; gi = gi + 1) begin : g_ch
         logic tx_s;
         logic bus_s;
         logic mode_ok;
         logic take;

         // Normal needs chip normal, receive-only chip normal or stop; off and wake always allowed
         assign mode_ok = (wr_mode[gi] == LMC_MODE_OFF) ||
                          (wr_mode[gi] == LMC_MODE_WAKE) ||
                          (sys_mode_i == LMC_SYS_NORMAL) ||
                          (sys_mode_i == LMC_SYS_STOP && wr_mode[gi] != LMC_MODE_NORM);
         assign take = frame_done_i && mode_ok;

         always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               mode_reg[gi] <= LMC_MODE_OFF;
            end else if (take) begin
               mode_reg[gi] <= wr_mode[gi];
            end else if (sys_mode_i != LMC_SYS_NORMAL && sys_mode_i != LMC_SYS_STOP &&
                         (mode_reg[gi] == LMC_MODE_NORM || mode_reg[gi] == LMC_MODE_RXO)) begin
               mode_reg[gi] <= LMC_MODE_OFF;
            end
         end

         lmc_sync3 u_tx_sync (
            .sys_clk_i (sys_clk_i),
            .rst_b_i   (rst_b_i),
            .d_i       (bus_transmit_input_i[gi]),
            .q_o       (tx_s)
         );
         lmc_sync3 u_bus_sync (
            .sys_clk_i (sys_clk_i),
            .rst_b_i   (rst_b_i),
            .d_i       (bus_level_i[gi]),
            .q_o       (bus_s)
         );
         lmc_channel u_ch (
            .sys_clk_i  (sys_clk_i),
            .rst_b_i    (rst_b_i),
            .mode_i     (mode_reg[gi]),
            .mode_new_i (take),
            .rearm_i    (rearm),
            .tx_i       (tx_s),
            .bus_i      (bus_s),
            .out_o      (ch_out[gi])
         );

         // Open drain: pull low only, oe high while dominant; 10.4 kbit/s is far below clock
         assign bus_drive_o[gi]    = 1'h0;
         assign bus_drive_oe_o[gi] = ch_out[gi].tx_drive;
         assign rx_o[gi]           = ch_out[gi].rx_level;
         assign wake_o[gi]         = ch_out[gi].wake_seen;
         assign mode_o[gi]         = mode_reg[gi];

         a_mode_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
            mode_reg[gi] == LMC_MODE_NORM |-> sys_prev_reg == LMC_SYS_NORMAL ||
            sys_prev_reg == LMC_SYS_STOP || $past(take))
            else $error("normal mode outside allowed chip mode");
         a_off_allowed: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
            frame_done_i && wr_mode[gi] == LMC_MODE_OFF |=> mode_reg[gi] == LMC_MODE_OFF)
            else $error("off mode write refused");
      end
   endgenerate
endmodule
`default_nettype wire

// ---- testbench/lmc_mcu_model.sv ----
`include "lmc_defs.svh"
`default_nettype none
module lmc_mcu_model
   import lmc_pkg::*;
(
   input  wire logic sys_clk_i,
   input  wire logic rst_b_i,
   input  wire logic start_i,
   input  wire logic bit_i,
   input  wire logic early_low_i,
   output logic      tx_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int hold_cnt;
   // Two spare cycles, since the delay start is not visible from outside
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) hold_cnt <= 0;
      else if (start_i) hold_cnt <= `LMC_EN_CYCLES + 2;
      else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
   end
   // Early low only when a scenario asks for the misbehaving controller
   assign tx_o = early_low_i ? 1'b0 : (hold_cnt != 0) ? 1'b1 : bit_i;
endmodule
`default_nettype wire

// ---- testbench/tb_lmc_top.sv ----
`include "lmc_defs.svh"
`default_nettype none
module tb_lmc_top import lmc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic            sys_clk_i, rst_b_i, frame_done_i;
   lmc_sys_t        sys_mode_i;
   lmc_mode_t       m_one, m_two;
   logic [1:0]      tx, bus_level, remote_dom, bit_v, early, start, oe, drv, rx, wake;
   lmc_mode_t [1:0] mode;
   lmc_mode_t       exp_mode [2];
   lmc_sys_t        sys_tab [4];
   logic            bits_q [$];
   int              fail_count, check_count, seed, i, j;
   ////////////////////////////////////////////////////////////////////////////
   lmc_top dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sys_mode_i(sys_mode_i),
      .bus_channel_one_mode_i(m_one), .bus_channel_two_mode_i(m_two),
      .frame_done_i(frame_done_i), .bus_transmit_input_i(tx), .bus_level_i(bus_level),
      .bus_drive_o(drv), .bus_drive_oe_o(oe), .rx_o(rx), .wake_o(wake), .mode_o(mode));
   for (genvar g = 0; g < 2; g++) begin : g_mcu
      lmc_mcu_model u_mcu (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .start_i(start[g]),
         .bit_i(bit_v[g]), .early_low_i(early[g]), .tx_o(tx[g]));
   end
   assign start = {frame_done_i & (m_two == LMC_MODE_NORM),
                   frame_done_i & (m_one == LMC_MODE_NORM)};
   // Wired bus with pull-up: dominant if either side pulls
   assign bus_level = ~(oe | remote_dom);
   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (fail_count == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string what, input logic [3:0] e, input logic [3:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask
   function automatic logic pick(input int sel, input int ch);
      return (sel == 0) ? oe[ch] : (sel == 1) ? rx[ch] : wake[ch];
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   // Bounded wait, pipeline is about five cycles
   task automatic wait_for(input string what, input int sel, input int ch, input logic v);
      int n;
      n = 0;
      while (pick(sel, ch) !== v && n < 20) begin
         cyc(1);
         n++;
      end
      chk(what, v, pick(sel, ch));
   endtask
   task automatic hold(input string what, input int sel, input int ch, input logic v,
                       input int n);
      repeat (n) begin
         cyc(1);
         chk(what, v, pick(sel, ch));
      end
   endtask
   task automatic chk_modes();
      chk("mode one", exp_mode[0], mode[0]);
      chk("mode two", exp_mode[1], mode[1]);
   endtask
   task automatic wr(input int ch, input lmc_mode_t m);
      logic      busy;
      lmc_mode_t mm;
      cyc(1);
      if (ch == 0) m_one = m;
      else m_two = m;
      frame_done_i = 1'b1;
      cyc(1);
      frame_done_i = 1'b0;
      busy = (sys_mode_i == LMC_SYS_NORMAL) || (sys_mode_i == LMC_SYS_STOP);
      // A frame carries both fields, so the untouched one is written again
      for (int c = 0; c < 2; c++) begin
         mm = (c == 0) ? m_one : m_two;
         if (mm == LMC_MODE_OFF || mm == LMC_MODE_WAKE || (mm == LMC_MODE_RXO && busy)
             || (mm == LMC_MODE_NORM && sys_mode_i == LMC_SYS_NORMAL)) exp_mode[c] = mm;
      end
      cyc(1);
      chk_modes();
   endtask
   task automatic set_sys(input lmc_sys_t s);
      cyc(1);
      sys_mode_i = s;
      for (int c = 0; c < 2; c++) begin
         if ((s == LMC_SYS_SLEEP || s == LMC_SYS_OTHER) && exp_mode[c] inside
             {LMC_MODE_NORM, LMC_MODE_RXO}) exp_mode[c] = LMC_MODE_OFF;
      end
      cyc(2);
      chk_modes();
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      repeat (40000) @(posedge sys_clk_i);
      fail_count++;
      complete_run();
   end
   initial begin
      seed = 26;
      fail_count = 0;
      check_count = 0;
      sys_mode_i = LMC_SYS_NORMAL;
      m_one = LMC_MODE_OFF;
      m_two = LMC_MODE_OFF;
      frame_done_i = 1'b0;
      bit_v = 2'h3;
      early = 2'h0;
      remote_dom = 2'h0;
      rst_b_i = 1'b0;
      exp_mode = '{LMC_MODE_OFF, LMC_MODE_OFF};
      sys_tab = '{LMC_SYS_NORMAL, LMC_SYS_STOP, LMC_SYS_SLEEP, LMC_SYS_OTHER};
      cyc(5);
      rst_b_i = 1'b1;
      chk_modes();
      chk("oe rx idle", 4'h3, {oe, rx});
      chk("wake drv idle", 4'h0, {wake, drv});
      wr(1, LMC_MODE_RXO);
      for (i = 0; i < 4; i++) begin
         set_sys(sys_tab[i]);
         for (j = 0; j < 4; j++) begin
            wr(0, lmc_mode_t'(j));
            wr(0, LMC_MODE_OFF);
         end
      end
      set_sys(LMC_SYS_NORMAL);
      early[0] = 1'b1;
      wr(0, LMC_MODE_NORM);
      hold("oe in delay", 0, 0, 1'b0, 120);
      early[0] = 1'b0;
      hold("oe low held", 0, 0, 1'b0, 10);
      bit_v[0] = 1'b0;
      wait_for("oe first bit", 0, 0, 1'b1);
      // Bits at 10.4 kbit/s, checked at mid-bit
      for (i = 0; i < 8; i++) begin
         bit_v[0] = 1'($random(seed));
         bits_q.push_back(bit_v[0]);
         cyc(481);
         chk("oe stream", !bits_q[0], oe[0]);
         chk("rx stream", bits_q[0], rx[0]);
         chk("other channel", 4'h1, {oe[1], rx[1]});
         void'(bits_q.pop_front());
         cyc(481);
      end
      wr(0, LMC_MODE_RXO);
      bit_v[0] = 1'b0;
      for (i = 0; i < 4; i++) begin
         remote_dom[0] = ~remote_dom[0];
         wait_for("rx only", 1, 0, ~remote_dom[0]);
         hold("oe rx only", 0, 0, 1'b0, 20);
      end
      bit_v[0] = 1'b1;
      wr(0, LMC_MODE_OFF);
      wr(1, LMC_MODE_OFF);
      remote_dom[1] = 1'b1;
      hold("rx off", 1, 1, 1'b1, 400);
      remote_dom[1] = 1'b0;
      hold("wake off", 2, 1, 1'b0, 20);
      wr(1, LMC_MODE_WAKE);
      remote_dom[1] = 1'b1;
      cyc(400);
      remote_dom[1] = 1'b0;
      wait_for("wake seen", 2, 1, 1'b1);
      wait_for("rx wake", 1, 1, 1'b0);
      hold("rx wake held", 1, 1, 1'b0, 30);
      chk_modes();
      wr(1, LMC_MODE_OFF);
      wait_for("rx released", 1, 1, 1'b1);
      complete_run();
   end
endmodule
`default_nettype wire
